/* File: pcm_regs.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "pcm_defs.svh"

// Function
// (R1) Platform bits 52:50 read the three-bit platform flag code, read-only
// (R2) Platform bits 56:53 read the second-level cache latency, read-only
// (R3) Platform bit 60 reads the clock frequency ratio indication, read-only
// (R4) Controller base bit 8 reads 1 on the bootstrap processor
// (R5) Controller base bit 11 is global enable, kept until next reset; here any controller base write can set or clear it
// (R6) Writable power-on bits switch their features when software writes them
// (R7) Read-only power-on bits return the configuration caught at power-on
// (R8) Power-on bit 1 enables system bus data error checking
// (R9) Power-on bit 2 enables response checking and redundancy error watch
// (R10) Power-on bit 3 enables driving the address error output
// (R11) Power-on bit 4 enables bus error output on initiated requests
// (R12) Power-on bit 6 enables bus error output on internal errors
// (R13) Power-on bit 7 enables driving the bus initialisation output
// (R14) Power-on bit 8 reads whether output tri-state mode is active
// (R15) Reserved bits read zero; writes to read-only bits change nothing

module pcm_regs
    import pcm_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic      [31:0] PRDATA,
    output logic             PSLVERR,
    input  wire logic [2:0]  PLATFORM_FLAG_PIN,
    input  wire logic [3:0]  L2_LATENCY_PIN,
    input  wire logic        CLOCK_RATIO_PIN,
    input  wire logic        BOOTSTRAP_PROCESSOR_PIN,
    input  wire logic        TRISTATE_MODE_PIN,
    input  wire logic [63:0] FAULT_ADDR,
    input  wire logic [63:0] FAULT_TYPE,
    output logic             DATA_ERR_CHECK_EN,
    output logic             RESP_ERR_CHECK_EN,
    output logic             ADDR_ERR_DRIVE_EN,
    output logic             BUS_ERR_REQ_EN,
    output logic             BUS_ERR_INT_EN,
    output logic             BUS_INIT_DRIVE_EN,
    output logic             INTC_GLOBAL_EN,
    output logic      [19:0] INTC_BASE_ADDR,
    output logic      [63:0] TIMESTAMP
);

    // Synchronised strap levels
    logic [2:0]    plat_flag_s;
    logic [3:0]    l2_lat_s;
    logic          clk_ratio_s;
    logic          boot_proc_s;
    logic          tristate_s;

    // Captured straps, fixed from capture until the next reset
    logic [2:0]    plat_flag_r;
    logic [3:0]    l2_lat_r;
    logic          clk_ratio_r;
    logic          boot_proc_r;
    logic          tristate_r;

    // Strap capture sequencer
    pcm_strap_st_t strap_st_r;
    pcm_strap_st_t strap_st_nxt;
    logic [1:0]    settle_cnt_r;

    // Software state
    logic          intc_en_r;
    logic [19:0]   intc_base_r;
    logic [7:0]    pon_rw_r;
    logic [31:0]   rd_hi_r;
    logic [31:0]   wr_hi_r;
    logic [63:0]   stamp_cnt;

    // Bus decode
    logic [9:0]    idx;
    logic          setup_ph;
    logic          access_ph;
    logic          wr_commit;
    logic [63:0]   wr_val;
    logic [63:0]   rd_view;
    logic          rd_hit;

    // Assembled 64-bit register views
    logic [63:0]   plat_view;
    logic [63:0]   intc_view;
    logic [63:0]   pon_view;

    // Strap pins come from outside the clock domain
    pcm_sync #(.W(10)) pcm_sync_inst (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .din   ({PLATFORM_FLAG_PIN, L2_LATENCY_PIN, CLOCK_RATIO_PIN,
                 BOOTSTRAP_PROCESSOR_PIN, TRISTATE_MODE_PIN}),
        .dout  ({plat_flag_s, l2_lat_s, clk_ratio_s,
                 boot_proc_s, tristate_s})
    );

    // Cycle counter behind the timestamp register
    pcm_stamp_cnt pcm_stamp_cnt_inst (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .load     (wr_commit && (idx == `PCM_IDX_STAMP)),
        .load_val (wr_val),
        .count    (stamp_cnt)
    );

    // Settle count lets the synchroniser fill before straps are caught
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_cnt_r <= 2'h0;
        end else if (strap_st_r == PCM_ST_SETTLE) begin
            settle_cnt_r <= settle_cnt_r + 2'h1;
        end
    end

    // Next state of the strap sequencer
    always_comb begin
        strap_st_nxt = strap_st_r;
        case (strap_st_r)
            PCM_ST_SETTLE: begin
                if (settle_cnt_r == `PCM_STRAP_SETTLE) begin
                    strap_st_nxt = PCM_ST_LATCH;
                end
            end
            PCM_ST_LATCH: begin
                strap_st_nxt = PCM_ST_RUN;
            end
            PCM_ST_RUN: begin
                strap_st_nxt = PCM_ST_RUN;
            end
            default: begin
                strap_st_nxt = PCM_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_st_r <= PCM_ST_SETTLE;
        end else begin
            strap_st_r <= strap_st_nxt;
        end
    end

    // Straps are caught once; later pin changes are ignored
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            plat_flag_r <= 3'h0;
            l2_lat_r    <= 4'h0;
            clk_ratio_r <= 1'b0;
            boot_proc_r <= 1'b0;
            tristate_r  <= 1'b0;
        end else if (strap_st_r == PCM_ST_LATCH) begin
            plat_flag_r <= plat_flag_s; // R1
            l2_lat_r    <= l2_lat_s; // R2
            clk_ratio_r <= clk_ratio_s; // R3
            boot_proc_r <= boot_proc_s; // R4
            tristate_r  <= tristate_s; // R7
        end
    end

    // Register views; every unnamed position is a constant zero
    assign plat_view = {3'h0, clk_ratio_r, 3'h0, l2_lat_r,
                        plat_flag_r, 50'h0}; // R1 R2 R3 R15
    assign intc_view = {32'h0, intc_base_r, intc_en_r, 2'h0,
                        boot_proc_r, 8'h00}; // R4 R15
    assign pon_view  = {55'h0, tristate_r, pon_rw_r}; // R14 R15

    // APB phase decode; word index ignores the byte lane bits
    assign idx       = PADDR[11:2];
    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign wr_commit = access_ph && PWRITE;
    assign wr_val    = {wr_hi_r, PWDATA};

    // Zero wait states: read data is prepared in the setup cycle
    assign PREADY = 1'b1;

    // Read selection over the 64-bit registers
    always_comb begin
        rd_view = 64'h0;
        rd_hit  = 1'b1;
        case (idx)
            `PCM_IDX_MC_ADDR:   rd_view = FAULT_ADDR;
            `PCM_IDX_MC_TYPE:   rd_view = FAULT_TYPE;
            `PCM_IDX_STAMP:     rd_view = stamp_cnt;
            `PCM_IDX_PLAT:      rd_view = plat_view;
            `PCM_IDX_INTC:      rd_view = intc_view;
            `PCM_IDX_PON:       rd_view = pon_view;
            `PCM_IDX_HI_SHADOW: rd_view = {32'h0, rd_hi_r};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // Read data and error come from flops loaded in the setup cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (setup_ph) begin
            PRDATA  <= PWRITE ? 32'h0 : rd_view[31:0];
            PSLVERR <= !rd_hit;
        end
    end

    // Reading a low word snapshots its high word so both halves agree
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_hi_r <= 32'h0;
        end else if (setup_ph && !PWRITE && rd_hit &&
                     (idx != `PCM_IDX_HI_SHADOW)) begin
            rd_hi_r <= rd_view[63:32];
        end
    end

    // High half of a 64-bit write is staged before the low word commits
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_hi_r <= 32'h0;
        end else if (wr_commit && (idx == `PCM_IDX_HI_SHADOW)) begin
            wr_hi_r <= PWDATA;
        end
    end

    // Global enable and base change only on a controller base write or a reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            intc_en_r   <= `PCM_INTC_EN_RST;
            intc_base_r <= `PCM_INTC_BASE_RST;
        end else if (wr_commit && (idx == `PCM_IDX_INTC)) begin
            intc_en_r   <= wr_val[`PCM_INTC_EN_BIT]; // R5
            intc_base_r <= wr_val[`PCM_INTC_BASE_MSB:`PCM_INTC_BASE_LSB];
        end
    end

    // Only the writable power-on bits take write data; mask keeps others 0
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pon_rw_r <= `PCM_PON_RW_RST;
        end else if (wr_commit && (idx == `PCM_IDX_PON)) begin
            pon_rw_r <= wr_val[7:0] & `PCM_PON_RW_MASK; // R6 R15
        end
    end

    // Feature enables driven straight from their register bits
    assign DATA_ERR_CHECK_EN = pon_rw_r[`PCM_PON_DATA_CHK]; // R8
    assign RESP_ERR_CHECK_EN = pon_rw_r[`PCM_PON_RESP_CHK]; // R9
    assign ADDR_ERR_DRIVE_EN = pon_rw_r[`PCM_PON_ADDR_ERR]; // R10
    assign BUS_ERR_REQ_EN    = pon_rw_r[`PCM_PON_BUSERR_REQ]; // R11
    assign BUS_ERR_INT_EN    = pon_rw_r[`PCM_PON_BUSERR_INT]; // R12
    assign BUS_INIT_DRIVE_EN = pon_rw_r[`PCM_PON_BUSINIT]; // R13
    assign INTC_GLOBAL_EN    = intc_en_r;
    assign INTC_BASE_ADDR    = intc_base_r;
    assign TIMESTAMP         = stamp_cnt;

    // Helper that lines the read snapshot up with 64-bit field positions
    logic [63:0] hi_chk;
    assign hi_chk = {rd_hi_r, 32'h0};

    a_plat_flag_read: assert property ( // R1
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !PWRITE && (idx == `PCM_IDX_PLAT)
        |=> hi_chk[`PCM_PLAT_FLAG_MSB:`PCM_PLAT_FLAG_LSB]
            == $past(plat_flag_r) && PRDATA == 32'h0)
        else $error("platform flag field misread");

    a_l2_latency_read: assert property ( // R2
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !PWRITE && (idx == `PCM_IDX_PLAT)
        |=> hi_chk[`PCM_PLAT_L2_MSB:`PCM_PLAT_L2_LSB] == $past(l2_lat_r))
        else $error("cache latency field misread");

    a_clk_ratio_read: assert property ( // R3
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !PWRITE && (idx == `PCM_IDX_PLAT)
        |=> hi_chk[`PCM_PLAT_RATIO_BIT] == $past(clk_ratio_r)
            && hi_chk[59:57] == 3'h0 && hi_chk[63:61] == 3'h0)
        else $error("clock ratio field misread");

    a_plat_ro_keep: assert property ( // R1 R7 R15
        @(posedge REF_CLK) disable iff (!RST_N)
        (strap_st_r == PCM_ST_RUN) ##0 wr_commit
        |=> $stable(plat_flag_r) && $stable(l2_lat_r)
            && $stable(clk_ratio_r)
            && $stable(boot_proc_r) && $stable(tristate_r))
        else $error("read-only field changed by a write");

    a_boot_bit_read: assert property ( // R4 R15
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !PWRITE && (idx == `PCM_IDX_INTC)
        |=> PRDATA[`PCM_INTC_BOOT_BIT] == $past(boot_proc_r)
            && PRDATA[7:0] == 8'h00 && PRDATA[10:9] == 2'h0)
        else $error("bootstrap indicator misread");

    a_global_en_write: assert property ( // R5
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_commit && (idx == `PCM_IDX_INTC)
        |=> INTC_GLOBAL_EN == $past(PWDATA[`PCM_INTC_EN_BIT]))
        else $error("global enable did not follow write");

    a_global_en_hold: assert property ( // R5
        @(posedge REF_CLK) disable iff (!RST_N)
        !(wr_commit && (idx == `PCM_IDX_INTC)) |=> $stable(INTC_GLOBAL_EN))
        else $error("global enable changed without a write");

    a_pon_write_bits: assert property ( // R6 R8 R9 R10 R11 R12 R13
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_commit && (idx == `PCM_IDX_PON)
        |=> {BUS_INIT_DRIVE_EN, BUS_ERR_INT_EN, BUS_ERR_REQ_EN,
             ADDR_ERR_DRIVE_EN, RESP_ERR_CHECK_EN, DATA_ERR_CHECK_EN}
            == {$past(PWDATA[7]), $past(PWDATA[6]), $past(PWDATA[4]),
                $past(PWDATA[3]), $past(PWDATA[2]), $past(PWDATA[1])})
        else $error("power-on enable bits did not follow write");

    a_pon_read_back: assert property ( // R14 R15
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !PWRITE && (idx == `PCM_IDX_PON)
        |=> PRDATA[`PCM_PON_TRISTATE] == $past(tristate_r)
            && PRDATA[0] == 1'b0 && PRDATA[5] == 1'b0
            && PRDATA[31:9] == 23'h0)
        else $error("power-on register misread");

    a_strap_capture: assert property ( // R7
        @(posedge REF_CLK) disable iff (!RST_N)
        (strap_st_r == PCM_ST_LATCH)
        |=> (strap_st_r == PCM_ST_RUN) && tristate_r == $past(tristate_s)
            && boot_proc_r == $past(boot_proc_s))
        else $error("straps not captured");

    a_unmapped_error: assert property ( // R15
        @(posedge REF_CLK) disable iff (!RST_N)
        setup_ph && !rd_hit |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped index not refused");

    a_pon_reserved: assert property ( // R15
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_commit && (idx == `PCM_IDX_PON)
        |=> pon_view[0] == 1'b0 && pon_view[5] == 1'b0
            && pon_view[63:9] == 55'h0)
        else $error("reserved power-on bits set by a write");

endmodule : pcm_regs

/* File: pcm_defs.svh */
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define PCM_IDX_MC_ADDR     10'h000
`define PCM_IDX_MC_TYPE     10'h001
`define PCM_IDX_STAMP       10'h010
`define PCM_IDX_PLAT        10'h017
`define PCM_IDX_INTC        10'h01b
`define PCM_IDX_PON         10'h02a
`define PCM_IDX_HI_SHADOW   10'h100

// Platform identification fields
`define PCM_PLAT_FLAG_MSB   52
`define PCM_PLAT_FLAG_LSB   50
`define PCM_PLAT_L2_MSB     56
`define PCM_PLAT_L2_LSB     53
`define PCM_PLAT_RATIO_BIT  60

// Interrupt controller base fields
`define PCM_INTC_BOOT_BIT   8
`define PCM_INTC_EN_BIT     11
`define PCM_INTC_BASE_MSB   31
`define PCM_INTC_BASE_LSB   12
`define PCM_INTC_EN_RST     1'b1
`define PCM_INTC_BASE_RST   20'h00000

// Hard power-on configuration fields
`define PCM_PON_DATA_CHK    1
`define PCM_PON_RESP_CHK    2
`define PCM_PON_ADDR_ERR    3
`define PCM_PON_BUSERR_REQ  4
`define PCM_PON_BUSERR_INT  6
`define PCM_PON_BUSINIT     7
`define PCM_PON_TRISTATE    8
`define PCM_PON_RW_MASK     8'hde
`define PCM_PON_RW_RST      8'h00

// Strap settling after reset release, in REF_CLK cycles
`define PCM_STRAP_SETTLE    2'd2

`endif

/* File: pcm_pkg.sv */
package pcm_pkg;

    // Strap capture sequence after reset release
    typedef enum logic [2:0] {
        PCM_ST_SETTLE = 3'b001,
        PCM_ST_LATCH  = 3'b010,
        PCM_ST_RUN    = 3'b100
    } pcm_strap_st_t;

endpackage : pcm_pkg

/* File: pcm_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for strap pins of any width
module pcm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule : pcm_sync

/* File: pcm_tsc.sv */
`timescale 1ns/1ps

// Free-running 64-bit cycle counter with a software load
module pcm_stamp_cnt (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [63:0] load_val,
    output logic      [63:0] count
);

    // A load wins over the increment in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 64'h0;
        end else if (load) begin
            count <= load_val;
        end else begin
            count <= count + 64'h1;
        end
    end

endmodule : pcm_stamp_cnt

/* File: pcm_regs_tb.sv */
`timescale 1ns/1ps

module pcm_regs_tb;

    typedef struct {
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [26:0] pins;
    } pcm_row_t;

    logic        REF_CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000;
    logic        PREADY;
    logic [31:0] PRDATA;
    logic        PSLVERR;
    logic [2:0]  PLATFORM_FLAG_PIN = 3'h5;
    logic [3:0]  L2_LATENCY_PIN = 4'ha;
    logic        CLOCK_RATIO_PIN = 1'b1;
    logic        BOOTSTRAP_PROCESSOR_PIN = 1'b1;
    logic        TRISTATE_MODE_PIN = 1'b1;
    logic [63:0] FAULT_ADDR = 64'h0123456789abcdef;
    logic [63:0] FAULT_TYPE = 64'hfedcba9876543210;
    logic        DATA_ERR_CHECK_EN;
    logic        RESP_ERR_CHECK_EN;
    logic        ADDR_ERR_DRIVE_EN;
    logic        BUS_ERR_REQ_EN;
    logic        BUS_ERR_INT_EN;
    logic        BUS_INIT_DRIVE_EN;
    logic        INTC_GLOBAL_EN;
    logic [19:0] INTC_BASE_ADDR;
    logic [63:0] TIMESTAMP;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic        err;
    logic [31:0] exp_v;

    // Every control output in one word: global enable, base, six enables
    wire logic [26:0] pins = {INTC_GLOBAL_EN, INTC_BASE_ADDR,
        BUS_INIT_DRIVE_EN, BUS_ERR_INT_EN, BUS_ERR_REQ_EN,
        ADDR_ERR_DRIVE_EN, RESP_ERR_CHECK_EN, DATA_ERR_CHECK_EN};

    // Write, then read back low word, high word and the control outputs
    pcm_row_t rows [13] = '{
        '{12'h000, 32'hffffffff, 32'h89abcdef, 32'h01234567, 27'h4000000},
        '{12'h004, 32'h00000000, 32'h76543210, 32'hfedcba98, 27'h4000000},
        '{12'h05c, 32'hffffffff, 32'h00000000, 32'h11540000, 27'h4000000},
        '{12'h06c, 32'habcde000, 32'habcde100, 32'h00000000, 27'h2af3780},
        '{12'h0a8, 32'hffffffff, 32'h000001de, 32'h00000000, 27'h2af37bf},
        '{12'h0a8, 32'hffffff21, 32'h00000100, 32'h00000000, 27'h2af3780},
        '{12'h0a8, 32'h00000002, 32'h00000102, 32'h00000000, 27'h2af3781},
        '{12'h0a8, 32'h00000004, 32'h00000104, 32'h00000000, 27'h2af3782},
        '{12'h0a8, 32'h00000008, 32'h00000108, 32'h00000000, 27'h2af3784},
        '{12'h0a8, 32'h00000010, 32'h00000110, 32'h00000000, 27'h2af3788},
        '{12'h0a8, 32'h00000040, 32'h00000140, 32'h00000000, 27'h2af3790},
        '{12'h0a8, 32'h00000080, 32'h00000180, 32'h00000000, 27'h2af37a0},
        '{12'h06c, 32'h00000800, 32'h00000900, 32'h00000000, 27'h4000020}
    };

    pcm_regs pcm_regs_inst (.*);

    always #2.5 REF_CLK = ~REF_CLK;

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic wr,
                       input logic [31:0] wd);
        int n;
        @(posedge REF_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 100);
        // A transfer that never completes is a failure, not a pass
        if (PREADY !== 1'b1) begin
            err_count++;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // Reset held 16 cycles, then time for the straps to be captured
    task automatic do_reset();
        RST_N <= 1'b0;
        repeat (16) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (10) @(posedge REF_CLK);
    endtask : do_reset

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    initial begin
        do_reset();
        chk(pins, 27'h4000000);
        chk(PREADY, 1'b1);
        // Table walk: read-only places keep their value, writable bits act
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, rows[i].wd);
            chk(err, 1'b0);
            apb(rows[i].addr, 1'b0, 32'h0);
            chk(rd, rows[i].lo);
            chk(err, 1'b0);
            apb(12'h400, 1'b0, 32'h0);
            chk(rd, rows[i].hi);
            chk(pins, rows[i].pins);
        end
        // Unmapped index is refused on both directions
        apb(12'h0fc, 1'b1, 32'hffffffff);
        chk(err, 1'b1);
        apb(12'h0fc, 1'b0, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        // Counter load through the staged high word, then it counts on
        apb(12'h400, 1'b1, 32'h00000001);
        apb(12'h040, 1'b1, 32'h00000010);
        apb(12'h040, 1'b0, 32'h0);
        chk(rd >= 32'h10 && rd <= 32'h18, 1'b1);
        apb(12'h400, 1'b0, 32'h0);
        chk(rd, 32'h00000001);
        chk(TIMESTAMP[63:32], 32'h00000001);
        // Every platform code, with the other straps varied alongside
        for (int f = 0; f < 8; f++) begin
            apb(12'h06c, 1'b1, 32'h00000000);
            apb(12'h0a8, 1'b1, 32'h000000de);
            chk(INTC_GLOBAL_EN, 1'b0);
            PLATFORM_FLAG_PIN       <= f[2:0];
            L2_LATENCY_PIN          <= {1'b0, f[2:0]} + 4'h3;
            CLOCK_RATIO_PIN         <= f[0];
            BOOTSTRAP_PROCESSOR_PIN <= f[1];
            TRISTATE_MODE_PIN       <= f[2];
            do_reset();
            chk(pins, 27'h4000000);
            apb(12'h05c, 1'b0, 32'h0);
            apb(12'h400, 1'b0, 32'h0);
            exp_v = {3'h0, f[0], ({4'h0, f[2:0]} + 7'h03), f[2:0], 18'h0};
            chk(rd, exp_v);
            apb(12'h06c, 1'b0, 32'h0);
            chk(rd, {20'h0, 1'b1, 2'b00, f[1], 8'h00});
            apb(12'h0a8, 1'b0, 32'h0);
            chk(rd, {23'h0, f[2], 8'h00});
        end
        end_of_test();
    end

endmodule : pcm_regs_tb
